// ==== mode_status_interrupt_ctrl.v ====
// Contract
// - Clearing one flag while another is pending releases the line 50 us.
// - Mode bit 7 low is standby: only bus, GPIO, key scanning work.
// - Mode bit 7 high allows backlight, aux LED and light sensor.
// - Bit 6 enables the backlight driver.
// - A written dim bit holds dim level until software clears it.
// - Dim timer non-zero: expiry sets the dim bit by hardware.
// - Overvoltage sets status bit 4, cleared by writing one.
// - Light comparator trip sets bit 3, cleared by writing one.
// - GPIO event sets bit 2; clears only after GPIO status cleared.
// - Key release sets flag; clears only after both release stats clear.
// - Key press sets flag; clears only after both press stats clear.
// - Dummy load on below code 8 linear or 32 square when enabled.
// - Enable bit 3 gates the light compare flag onto the line.
// - Enable bits 2,1,0 gate overvoltage, release, press flags.
// - All registers reset to zero; unused bits read zero.
// - Registers reached over two-wire bus at write address 0x64.
`timescale 1ns/1ps
`default_nettype none
`include "mode_status_consts.vh"

module mode_status_interrupt_ctrl #(
  parameter integer INT_GAP_CYCLES = `INT_GAP_CYCLES
) (
  // Clock and reset
  input wire CLOCK_I,
  input wire NRST_I,
  // Two-wire serial bus
  input wire SCL_I,
  input wire SDA_I,
  output wire SDA_O,
  output wire SDA_OE_N_O,
  // Event pulses from the analog and keypad blocks
  input wire OVERVOLTAGE_EVT_I,
  input wire LIGHT_COMPARE_EVT_I,
  input wire GPIO_INPUT_EVT_I,
  input wire KEY_RELEASE_EVT_I,
  input wire KEY_PRESS_EVT_I,
  // Lower level status still pending (blocks clearing)
  input wire GPIO_STAT_PENDING_I,
  input wire KEY_RELEASE_PENDING_I,
  input wire KEY_PRESS_PENDING_I,
  // Dim timer and backlight code
  input wire [3:0] DIM_DELAY_TIMER_I,
  input wire DIM_TIMER_EXPIRE_I,
  input wire [6:0] BACKLIGHT_CODE_I,
  input wire [1:0] BACKLIGHT_LAW_I,
  // Function controls
  output reg OPERATING_MODE_O,
  output reg BACKLIGHT_DRIVE_ENABLE_O,
  output reg DIM_ACTIVE_O,
  output reg DUMMY_LOAD_O,
  // Interrupt line to the host
  output reg INT_N_O
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Sticky flag: a set in the same cycle as a clear wins
  function flag_update;
    input cur;
    input set;
    input clr;
    begin
      flag_update = set | (cur & ~clr);
    end
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  wire [7:0] bus_addr;
  wire [7:0] bus_wdata;
  wire bus_wr;
  reg [7:0] bus_rdata;

  twowire_reg_slave slave_u (
    .clk_i(CLOCK_I),
    .nrst_i(NRST_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .sda_oe_n_o(SDA_OE_N_O),
    .addr_o(bus_addr),
    .wdata_o(bus_wdata),
    .wr_o(bus_wr),
    .rdata_i(bus_rdata)
  );

  // Pin only ever pulled low
  assign SDA_O = 1'b0;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [2:0] mode_reg; // operating mode, backlight enable, dim
  reg [4:0] flags_reg;
  reg [4:0] ien_reg;
  reg [15:0] gap_reg;

  wire wr_mode = bus_wr && (bus_addr == `OFS_MODE_AND_STATUS);
  wire wr_ien = bus_wr && (bus_addr == `OFS_INTERRUPT_ENABLES);

  // Clear strobes; clear-first dependencies hold the lower flags
  wire clr_ovp = wr_mode & bus_wdata[`BIT_OVERVOLTAGE];
  wire clr_cmp = wr_mode & bus_wdata[`BIT_LIGHT_COMPARE];
  wire clr_gpi = wr_mode & bus_wdata[`BIT_GPIO_INPUT] & ~GPIO_STAT_PENDING_I;
  wire clr_kr = wr_mode & bus_wdata[`BIT_KEY_RELEASE] & ~KEY_RELEASE_PENDING_I;
  wire clr_kp = wr_mode & bus_wdata[`BIT_KEY_PRESS] & ~KEY_PRESS_PENDING_I;

  // Hardware dim request only with a programmed timer
  wire dim_set = DIM_TIMER_EXPIRE_I & (DIM_DELAY_TIMER_I != 4'h0);

  reg [4:0] flags_next;
  reg [2:0] mode_next;

  // Next state of flags and mode bits
  always @* begin
    flags_next[`BIT_OVERVOLTAGE] = flag_update(flags_reg[`BIT_OVERVOLTAGE],
      OVERVOLTAGE_EVT_I, clr_ovp);
    flags_next[`BIT_LIGHT_COMPARE] = flag_update(flags_reg[`BIT_LIGHT_COMPARE],
      LIGHT_COMPARE_EVT_I, clr_cmp);
    flags_next[`BIT_GPIO_INPUT] = flag_update(flags_reg[`BIT_GPIO_INPUT],
      GPIO_INPUT_EVT_I, clr_gpi);
    flags_next[`BIT_KEY_RELEASE] = flag_update(flags_reg[`BIT_KEY_RELEASE],
      KEY_RELEASE_EVT_I, clr_kr);
    flags_next[`BIT_KEY_PRESS] = flag_update(flags_reg[`BIT_KEY_PRESS],
      KEY_PRESS_EVT_I, clr_kp);
    mode_next = mode_reg;
    if (wr_mode) begin
      mode_next = bus_wdata[7:5];
    end
    if (dim_set) begin
      mode_next[`BIT_DIM_EN - 5] = 1'b1;
    end
  end

  // Enabled sources; GPIO flag has no enable bit and always reaches the line
  function [4:0] gate_flags;
    input [4:0] f;
    input [4:0] e;
    begin
      gate_flags[`BIT_OVERVOLTAGE] = f[`BIT_OVERVOLTAGE] & e[`BIT_OVERVOLTAGE_IEN];
      gate_flags[`BIT_LIGHT_COMPARE] = f[`BIT_LIGHT_COMPARE] & e[`BIT_LIGHT_CMP_IEN];
      gate_flags[`BIT_GPIO_INPUT] = f[`BIT_GPIO_INPUT];
      gate_flags[`BIT_KEY_RELEASE] = f[`BIT_KEY_RELEASE] & e[`BIT_KEY_RELEASE_IEN];
      gate_flags[`BIT_KEY_PRESS] = f[`BIT_KEY_PRESS] & e[`BIT_KEY_PRESS_IEN];
    end
  endfunction

  wire [4:0] ien_next = wr_ien ? bus_wdata[4:0] : ien_reg;
  wire irq_pending_next = |gate_flags(flags_next, ien_next);
  // A software clear that actually dropped some flag
  wire flag_dropped = wr_mode & |(flags_reg & ~flags_next);

  // ----------------------------------------
  // Register and interrupt state
  // ----------------------------------------
  always @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_reg <= `RST_MODE;
      flags_reg <= `RST_FLAGS;
      ien_reg <= `RST_ENABLES;
      gap_reg <= 16'h0000;
    end else begin
      mode_reg <= mode_next;
      flags_reg <= flags_next;
      ien_reg <= ien_next;
      // Gap restarts on each clear that leaves something pending
      if (flag_dropped && irq_pending_next) begin
        gap_reg <= INT_GAP_CYCLES[15:0];
      end else if (gap_reg != 16'h0000) begin
        gap_reg <= gap_reg - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Registered so the line and controls never glitch
  always @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      OPERATING_MODE_O <= 1'b0;
      BACKLIGHT_DRIVE_ENABLE_O <= 1'b0;
      DIM_ACTIVE_O <= 1'b0;
      DUMMY_LOAD_O <= 1'b0;
      INT_N_O <= 1'b1;
    end else begin
      // Standby blocks every analog function
      OPERATING_MODE_O <= mode_reg[`BIT_OPERATING_MODE - 5];
      BACKLIGHT_DRIVE_ENABLE_O <= mode_reg[`BIT_OPERATING_MODE - 5] &
        mode_reg[`BIT_BACKLIGHT_EN - 5];
      DIM_ACTIVE_O <= mode_reg[`BIT_OPERATING_MODE - 5] &
        mode_reg[`BIT_BACKLIGHT_EN - 5] & mode_reg[`BIT_DIM_EN - 5];
      // Cubic laws have no threshold and never load
      DUMMY_LOAD_O <= ien_reg[`BIT_DUMMY_LOAD_EN] & mode_reg[`BIT_OPERATING_MODE - 5] &
        (((BACKLIGHT_LAW_I == `LAW_LINEAR) && (BACKLIGHT_CODE_I < `LOAD_THRESH_LINEAR)) ||
        ((BACKLIGHT_LAW_I == `LAW_SQUARE) && (BACKLIGHT_CODE_I < `LOAD_THRESH_SQUARE)));
      INT_N_O <= ~(irq_pending_next & ~(flag_dropped | (gap_reg > 16'h0001)));
    end
  end

  // Read data; unmapped addresses and unused bits read zero
  always @* begin
    case (bus_addr)
      `OFS_MODE_AND_STATUS: bus_rdata = {mode_reg, flags_reg};
      `OFS_INTERRUPT_ENABLES: bus_rdata = {3'h0, ien_reg};
      default: bus_rdata = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

// ==== mode_status_consts.vh ====
`ifndef MODE_STATUS_CONSTS_VH
`define MODE_STATUS_CONSTS_VH

// ----------------------------------------
// Serial bus
// ----------------------------------------
// 7-bit device address, 0x64 as write byte
`define DEV_ADDR7 7'h32

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_MODE_AND_STATUS 8'h00
`define OFS_INTERRUPT_ENABLES 8'h01

// ----------------------------------------
// Mode and status field positions
// ----------------------------------------
`define BIT_OPERATING_MODE 7
`define BIT_BACKLIGHT_EN 6
`define BIT_DIM_EN 5
`define BIT_OVERVOLTAGE 4
`define BIT_LIGHT_COMPARE 3
`define BIT_GPIO_INPUT 2
`define BIT_KEY_RELEASE 1
`define BIT_KEY_PRESS 0

// ----------------------------------------
// Interrupt enable field positions
// ----------------------------------------
`define BIT_DUMMY_LOAD_EN 4
`define BIT_LIGHT_CMP_IEN 3
`define BIT_OVERVOLTAGE_IEN 2
`define BIT_KEY_RELEASE_IEN 1
`define BIT_KEY_PRESS_IEN 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_MODE 3'h0
`define RST_FLAGS 5'h00
`define RST_ENABLES 5'h00

// ----------------------------------------
// Dummy load thresholds and law codes
// ----------------------------------------
`define LAW_LINEAR 2'h0
`define LAW_SQUARE 2'h1
`define LOAD_THRESH_LINEAR 7'h08
`define LOAD_THRESH_SQUARE 7'h20

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_FREQ_MHZ 250
`define INT_GAP_TIME_US 50
`define INT_GAP_CYCLES (`INT_GAP_TIME_US * `CLK_FREQ_MHZ)

`endif

// ==== twowire_reg_slave.v ====
`timescale 1ns/1ps
`default_nettype none
`include "mode_status_consts.vh"

module twowire_reg_slave (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Serial pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_oe_n_o,
  // Register side
  output reg [7:0] addr_o,
  output reg [7:0] wdata_o,
  output reg wr_o,
  input wire [7:0] rdata_i
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_DEV = 5'h02;
  localparam [4:0] S_REG = 5'h04;
  localparam [4:0] S_WR = 5'h08;
  localparam [4:0] S_RD = 5'h10;

  reg [4:0] state_reg;
  reg scl_reg;
  reg sda_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_reg;
  reg ack_reg;
  reg rw_reg;
  reg drive_low_reg;

  wire scl_rise = scl_i & ~scl_reg;
  wire scl_fall = ~scl_i & scl_reg;
  wire start_cond = scl_i & scl_reg & sda_reg & ~sda_i;
  wire stop_cond = scl_i & scl_reg & ~sda_reg & sda_i;

  // Open drain: only ever pulls low
  assign sda_oe_n_o = ~drive_low_reg;

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  // Pins are synchronous, so one stage of history suffices for edges
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= S_IDLE;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      ack_reg <= 1'b0;
      rw_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      addr_o <= 8'h00;
      wdata_o <= 8'h00;
      wr_o <= 1'b0;
    end else begin
      scl_reg <= scl_i;
      sda_reg <= sda_i;
      wr_o <= 1'b0;
      if (start_cond) begin
        state_reg <= S_DEV;
        bit_reg <= 4'h0;
        ack_reg <= 1'b0;
        drive_low_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= S_IDLE;
        ack_reg <= 1'b0;
        drive_low_reg <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == S_RD) begin
          bit_reg <= bit_reg + 4'h1;
          // Master NACK ends the read
          if (bit_reg == 4'h8 && sda_i) begin
            state_reg <= S_IDLE;
          end
        end else if (!ack_reg && bit_reg != 4'h8 && state_reg != S_IDLE) begin
          shift_reg <= {shift_reg[6:0], sda_i};
          bit_reg <= bit_reg + 4'h1;
        end
      end else if (scl_fall) begin
        case (state_reg)
          S_DEV: begin
            if (ack_reg) begin
              ack_reg <= 1'b0;
              bit_reg <= 4'h0;
              if (rw_reg) begin
                state_reg <= S_RD;
                shift_reg <= rdata_i;
                drive_low_reg <= ~rdata_i[7];
              end else begin
                state_reg <= S_REG;
                drive_low_reg <= 1'b0;
              end
            end else if (bit_reg == 4'h8) begin
              if (shift_reg[7:1] == `DEV_ADDR7) begin
                ack_reg <= 1'b1;
                drive_low_reg <= 1'b1;
                rw_reg <= shift_reg[0];
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_REG, S_WR: begin
            if (ack_reg) begin
              ack_reg <= 1'b0;
              drive_low_reg <= 1'b0;
              bit_reg <= 4'h0;
              state_reg <= S_WR;
            end else if (bit_reg == 4'h8) begin
              ack_reg <= 1'b1;
              drive_low_reg <= 1'b1;
              if (state_reg == S_REG) begin
                addr_o <= shift_reg;
              end else begin
                wdata_o <= shift_reg;
                wr_o <= 1'b1;
              end
            end
          end
          S_RD: begin
            if (bit_reg == 4'h9) begin
              // Master acked: send the same register again
              shift_reg <= rdata_i;
              drive_low_reg <= ~rdata_i[7];
              bit_reg <= 4'h0;
            end else if (bit_reg == 4'h8) begin
              drive_low_reg <= 1'b0;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              drive_low_reg <= ~shift_reg[6];
            end
          end
          default: begin
            drive_low_reg <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== mode_status_interrupt_ctrl_dummy_guard.v ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bus_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mode_status_consts.vh"
module bus_host (
  // Clock
  input wire logic clk_i,
  // Resolved data line and host drives
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Released lines at time zero, the pull-up holds both high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One bit: data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    hold(2);
    sda_o <= b;
    hold(2);
    scl_o <= 1'b1;
    hold(3);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, nak);
  endtask
  // Start and repeated start share one shape
  task automatic start();
    hold(2);
    sda_o <= 1'b1;
    hold(2);
    scl_o <= 1'b1;
    hold(3);
    sda_o <= 1'b0;
    hold(3);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    hold(2);
    sda_o <= 1'b0;
    hold(2);
    scl_o <= 1'b1;
    hold(3);
    sda_o <= 1'b1;
    hold(3);
  endtask
  // Write: device byte 0x64, register, data
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic [2:0] k;
    start();
    xfer({`DEV_ADDR7, 1'b0}, q, k[0]);
    xfer(a, q, k[1]);
    xfer(d, q, k[2]);
    stop();
    nak = |k;
  endtask
  // Read: register address, repeated start, 0x65, one byte then no ack
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic [3:0] k;
    start();
    xfer({`DEV_ADDR7, 1'b0}, q, k[0]);
    xfer(a, q, k[1]);
    start();
    xfer({`DEV_ADDR7, 1'b1}, q, k[2]);
    xfer(8'hff, d, k[3]);
    stop();
    nak = |k[2:0];
  endtask
endmodule
`default_nettype wire

// ==== mode_status_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module mode_status_monitor #(
  parameter integer INT_GAP_CYCLES = 8
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  // Watched ports
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N_O,
  input wire logic GPIO_INPUT_EVT_I,
  input wire logic [6:0] BACKLIGHT_CODE_I,
  input wire logic [1:0] BACKLIGHT_LAW_I,
  input wire logic OPERATING_MODE_O,
  input wire logic BACKLIGHT_DRIVE_ENABLE_O,
  input wire logic DIM_ACTIVE_O,
  input wire logic DUMMY_LOAD_O,
  input wire logic INT_N_O
);
  // A gap in progress may delay the line by its whole length
  localparam int GAP_LIM = INT_GAP_CYCLES + 2;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_gpio_evt;
    GPIO_INPUT_EVT_I;
  endsequence
  sequence s_int_low;
    ##[1:GAP_LIM] !INT_N_O;
  endsequence
  a_bl_needs_mode: assert property (BACKLIGHT_DRIVE_ENABLE_O |-> OPERATING_MODE_O)
    else $error("backlight on in standby");
  a_load_needs_mode: assert property (DUMMY_LOAD_O |-> OPERATING_MODE_O)
    else $error("dummy load on in standby");
  a_dim_needs_bl: assert property (DIM_ACTIVE_O |-> BACKLIGHT_DRIVE_ENABLE_O)
    else $error("dim without backlight");
  a_load_thresh: assert property (DUMMY_LOAD_O |-> $past((BACKLIGHT_LAW_I == 2'h0 &&
    BACKLIGHT_CODE_I < 7'h08) || (BACKLIGHT_LAW_I == 2'h1 && BACKLIGHT_CODE_I < 7'h20)))
    else $error("dummy load above threshold");
  a_load_cubic_off: assert property ($past(BACKLIGHT_LAW_I[1]) |-> !DUMMY_LOAD_O)
    else $error("dummy load under cubic law");
  a_gpio_raises_int: assert property (s_gpio_evt |-> s_int_low)
    else $error("gpio event left line high");
  a_ack_low_scl: assert property ($changed(SDA_OE_N_O) |-> $past(!SCL_I))
    else $error("data drive changed with clock high");
  a_sda_low_only: assert property (SDA_O == 1'b0)
    else $error("data pin driven high");
  a_reset_idle: assert property (!$past(NRST_I) |-> INT_N_O && SDA_OE_N_O)
    else $error("outputs not idle after reset");
endmodule
bind mode_status_interrupt_ctrl mode_status_monitor #(.INT_GAP_CYCLES(INT_GAP_CYCLES))
  i_mode_status_monitor (.CLOCK_I, .NRST_I, .SCL_I, .SDA_O, .SDA_OE_N_O, .GPIO_INPUT_EVT_I,
  .BACKLIGHT_CODE_I, .BACKLIGHT_LAW_I, .OPERATING_MODE_O, .BACKLIGHT_DRIVE_ENABLE_O,
  .DIM_ACTIVE_O, .DUMMY_LOAD_O, .INT_N_O);
`default_nettype wire

// ==== mode_status_interrupt_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module mode_status_interrupt_ctrl_tb;
  // Short gap keeps the run brief
  localparam int GAP = 8;
  logic clk = 1'b0, nrst = 1'b0, dexp = 1'b0, nak;
  logic [4:0] evt = 5'h00;
  logic [2:0] pend = 3'h0;
  logic [3:0] dimt = 4'h0;
  logic [6:0] code = 7'h00;
  logic [1:0] law = 2'h0;
  logic [7:0] q, fm;
  logic [9:0] lt [5] = '{{2'h0, 7'h07, 1'b1}, {2'h0, 7'h08, 1'b0}, {2'h1, 7'h1f, 1'b1},
    {2'h1, 7'h20, 1'b0}, {2'h2, 7'h00, 1'b0}};
  int fk [5] = '{4, 3, 1, 0, 2};
  logic [7:0] fe [5] = '{8'h04, 8'h08, 8'h02, 8'h01, 8'h00};
  int fail_count = 0, n_checks = 0, run = 0, last_run = 0;
  wire scl, sda_m, sda, sda_oe_n, sda_out, opm, ble, dim, load, int_n;
  // Pull-up: low when either side pulls
  assign sda = sda_m & (sda_oe_n | sda_out);
  always #2 clk = ~clk;
  bus_host i_bus_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  mode_status_interrupt_ctrl #(.INT_GAP_CYCLES(GAP)) i_mode_status_interrupt_ctrl (
    .CLOCK_I(clk), .NRST_I(nrst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_out),
    .SDA_OE_N_O(sda_oe_n), .OVERVOLTAGE_EVT_I(evt[4]), .LIGHT_COMPARE_EVT_I(evt[3]),
    .GPIO_INPUT_EVT_I(evt[2]), .KEY_RELEASE_EVT_I(evt[1]), .KEY_PRESS_EVT_I(evt[0]),
    .GPIO_STAT_PENDING_I(pend[2]), .KEY_RELEASE_PENDING_I(pend[1]),
    .KEY_PRESS_PENDING_I(pend[0]), .DIM_DELAY_TIMER_I(dimt), .DIM_TIMER_EXPIRE_I(dexp),
    .BACKLIGHT_CODE_I(code), .BACKLIGHT_LAW_I(law), .OPERATING_MODE_O(opm),
    .BACKLIGHT_DRIVE_ENABLE_O(ble), .DIM_ACTIVE_O(dim), .DUMMY_LOAD_O(load), .INT_N_O(int_n));
  // Length of the last high stretch of the interrupt line
  always @(posedge clk) begin
    if (int_n === 1'b1) begin
      run <= run + 1;
    end else begin
      if (run != 0) last_run <= run;
      run <= 0;
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_bus_host.wr(a, d, nak);
    check("ack", nak, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    i_bus_host.rd(a, q, nak);
    check("ack", nak, 8'h00);
    check(name, q, exp);
  endtask
  // One-cycle event pulses, settled two edges later
  task automatic pulse(input logic [4:0] e, input logic x);
    @(posedge clk);
    evt <= e;
    dexp <= x;
    @(posedge clk);
    evt <= 5'h00;
    dexp <= 1'b0;
    tick(2);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    fail_count++;
    stop_test();
  end
  initial begin
    tick(3);
    nrst <= 1'b1;
    tick(1);
    check("int", int_n, 8'h01);
    rd(8'h00, 8'h00, "mode");
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h1f, "ien");
    wr(8'h05, 8'h55);
    rd(8'h05, 8'h00, "unmapped");
    wr(8'h00, 8'h60);
    check("bl", ble, 8'h00);
    check("dim", dim, 8'h00);
    wr(8'h00, 8'he0);
    check("mode", opm, 8'h01);
    check("bl", ble, 8'h01);
    rd(8'h00, 8'he0, "mode rb");
    wr(8'h00, 8'hc0);
    check("dim", dim, 8'h00);
    pulse(5'h00, 1'b1);
    check("dim", dim, 8'h00);
    dimt <= 4'h3;
    pulse(5'h00, 1'b1);
    check("dim", dim, 8'h01);
    wr(8'h00, 8'h80);
    check("bl", ble, 8'h00);
    // Threshold table; cubic law never loads
    for (int i = 0; i < 5; i++) begin
      law <= lt[i][9:8];
      code <= lt[i][7:1];
      tick(3);
      check("load", load, {7'h00, lt[i][0]});
    end
    law <= 2'h0;
    wr(8'h01, 8'h00);
    check("load", load, 8'h00);
    // Per flag: masked (not GPIO), enabled, clear blocked for the lower three, clear
    for (int i = 0; i < 5; i++) begin
      pend <= 3'h7;
      fm = 8'h80 | (8'h01 << fk[i]);
      pulse(5'h01 << fk[i], 1'b0);
      rd(8'h00, fm, "flag");
      check("int", int_n, {7'h00, fe[i] != 8'h00});
      wr(8'h01, fe[i]);
      tick(2);
      check("int", int_n, 8'h00);
      wr(8'h00, 8'h80 | (8'h01 << fk[i]));
      rd(8'h00, fk[i] < 3 ? fm : 8'h80, "block");
      pend <= 3'h0;
      wr(8'h00, 8'h80 | (8'h01 << fk[i]));
      rd(8'h00, 8'h80, "clear");
      check("int", int_n, 8'h01);
    end
    // Clearing one flag with another pending opens a gap
    wr(8'h01, 8'h0c);
    pulse(5'h18, 1'b0);
    check("int", int_n, 8'h00);
    wr(8'h00, 8'h90);
    tick(GAP + 4);
    check("gap", last_run[7:0], GAP[7:0]);
    check("int", int_n, 8'h00);
    rd(8'h00, 8'h88, "pending");
    // Reset in mid-run while a flag is still pending and the bus is idle
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    check("int", int_n, 8'h01);
    check("mode", opm, 8'h00);
    rd(8'h00, 8'h00, "mode");
    rd(8'h01, 8'h00, "ien");
    stop_test();
  end
endmodule
`default_nettype wire
